// ==== rtl/bsp_sequencer.sv ====
// control and protection sequencer of the step-down converter
`timescale 1ns/1ps
module bsp_sequencer #(
  parameter int unsigned HIC_WAIT = bsp_pkg::HIC_WAIT_CYC,
  parameter int unsigned HIC_RESTART = bsp_pkg::HIC_RESTART_CYC,
  parameter int unsigned THERM_HIC = bsp_pkg::THERM_HIC_CYC,
  parameter int unsigned SOFT_CYC = bsp_pkg::SOFTSTART_CYC,
  parameter int unsigned CYCLE_DIV = bsp_pkg::CYCLE_CLKS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enableAbove, // enable comparator, high above threshold
  input wire logic supplyLockout, // high while input supply below lockout
  input wire logic bootLow, // boot capacitor below its threshold
  input wire logic peakTrip, // peak current reached the loop level
  input wire logic lightLoad, // peak current below skip threshold
  input wire logic valleyOver, // low-side sourcing current over limit
  input wire logic overvoltageHigh, // feedback above upper threshold
  input wire logic overvoltageLow, // feedback below lower threshold
  input wire logic overTemp, // junction overtemperature indication
  input wire logic softAboveFb, // soft-start level above feedback
  output logic highDrive,
  output logic lowDrive,
  output logic [15:0] softLevel, // soft-start ramp, full scale at end
  output logic softDone,
  output logic pulseSkip,
  output logic overvoltageMask,
  output logic valleyLimit,
  output logic hiccupActive,
  output logic thermalActive
);
  localparam int unsigned CW = 16;

  // refuse counts that the 16-bit counters cannot serve
  if (HIC_WAIT < 1 || HIC_RESTART < 1 || THERM_HIC < 1 || SOFT_CYC < 1)
  begin
    $error("hiccup and soft-start counts must be at least one");
  end
  // the overload counter saturates, so the wait must stay within it
  if (HIC_WAIT >= 65536 || HIC_RESTART >= 65536 || THERM_HIC > 65536
    || SOFT_CYC >= 65536)
  begin
    $error("counts exceed counter width");
  end

  // two-flop synchronisers for every comparator input
  localparam int unsigned NIN = 10;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] syncA; // first stage, read only by syncB
  logic [NIN-1:0] syncB;
  assign rawIn = {enableAbove, supplyLockout, bootLow, peakTrip, lightLoad,
    valleyOver, overvoltageHigh, overvoltageLow, overTemp, softAboveFb};

  // comparators are asynchronous to the core clock
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      syncA <= '0;
      syncB <= '0;
    end
    else
    begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  logic sEnable, sLockout, sBootLow, sPeak, sLight, sValley;
  logic sOvHigh, sOvLow, sHot, sSoftAbove;
  assign sEnable = syncB[9];
  assign sLockout = syncB[8];
  assign sBootLow = syncB[7];
  assign sPeak = syncB[6];
  assign sLight = syncB[5];
  assign sValley = syncB[4];
  assign sOvHigh = syncB[3];
  assign sOvLow = syncB[2];
  assign sHot = syncB[1];
  assign sSoftAbove = syncB[0];

  // cycle-start enable from the oscillator
  logic cycleStart;
  bsp_oscillator #(
    .DIVIDE(CYCLE_DIV)
  ) osc (
    .core_clk(core_clk),
    .rst(rst),
    .cycleStart(cycleStart)
  );

  // enable and supply lockout act as a reset of the whole sequence
  logic powerOk;
  assign powerOk = sEnable && !sLockout; // RL4 RL5

  bsp_pkg::bsp_state_e state;
  logic [CW-1:0] count; // cycle counter shared by soft-start and hiccups
  logic [CW-1:0] overloadCount; // consecutive overloaded cycles
  logic preBiasOk; // soft-start has passed feedback since start

  // sequencer: idle, soft-start, run, overcurrent and thermal hiccup
  always_ff @(posedge core_clk)
  begin
    if (rst || !powerOk)
    begin
      state <= bsp_pkg::BSP_IDLE; // RL4 RL5
      count <= '0;
    end
    else
    begin
      unique case (state)
        bsp_pkg::BSP_IDLE:
        begin
          state <= bsp_pkg::BSP_SOFT;
          count <= '0;
        end
        bsp_pkg::BSP_SOFT, bsp_pkg::BSP_RUN:
        begin
          if (sHot)
          begin
            state <= bsp_pkg::BSP_THERMAL; // RL14
            count <= '0;
          end
          else if (cycleStart && overloadCount >= CW'(HIC_WAIT))
          begin
            state <= bsp_pkg::BSP_HICCUP; // RL13
            count <= '0;
          end
          else if (state == bsp_pkg::BSP_SOFT && cycleStart)
          begin
            // ramp length counted in oscillator cycles
            if (count == CW'(SOFT_CYC - 1))
              state <= bsp_pkg::BSP_RUN; // RL10
            count <= count + CW'(1);
          end
        end
        bsp_pkg::BSP_HICCUP:
        begin
          if (sHot)
          begin
            state <= bsp_pkg::BSP_THERMAL;
            count <= '0;
          end
          else if (cycleStart)
          begin
            if (count == CW'(HIC_RESTART - 1))
            begin
              state <= bsp_pkg::BSP_SOFT; // RL13 RL15
              count <= '0;
            end
            else
              count <= count + CW'(1);
          end
        end
        bsp_pkg::BSP_THERMAL:
        begin
          // the interval counts only once the indication has cleared
          if (sHot)
            count <= '0;
          else if (cycleStart)
          begin
            if (count == CW'(THERM_HIC - 1))
            begin
              state <= bsp_pkg::BSP_SOFT; // RL14 RL15
              count <= '0;
            end
            else
              count <= count + CW'(1);
          end
        end
        default:
        begin
          state <= bsp_pkg::BSP_IDLE;
          count <= '0;
        end
      endcase
    end
  end

  logic switching;
  assign switching = (state == bsp_pkg::BSP_SOFT)
    || (state == bsp_pkg::BSP_RUN);

  // soft-start reference level, restarted on every start
  always_ff @(posedge core_clk)
  begin
    if (rst || !switching)
      softLevel <= '0; // RL15
    // jump to full scale on the edge that enters run, so the two agree
    else if (state == bsp_pkg::BSP_SOFT && cycleStart
      && count == CW'(SOFT_CYC - 1))
      softLevel <= 16'hFFFF; // RL10
    else if (state == bsp_pkg::BSP_SOFT)
      softLevel <= count;
    else
      softLevel <= 16'hFFFF;
  end
  assign softDone = (state == bsp_pkg::BSP_RUN);

  // pre-bias gate: once soft-start passes feedback it stays open
  always_ff @(posedge core_clk)
  begin
    if (rst || !switching)
      preBiasOk <= 1'b0;
    else if (sSoftAbove)
      preBiasOk <= 1'b1; // RL9
  end

  // overvoltage mask with hysteresis between the two thresholds
  always_ff @(posedge core_clk)
  begin
    if (rst || !switching)
      overvoltageMask <= 1'b0;
    else if (sOvHigh)
      overvoltageMask <= 1'b1; // RL8
    else if (sOvLow)
      overvoltageMask <= 1'b0; // RL8
  end

  // pulse skip: entered on a light peak, left on a heavier one
  always_ff @(posedge core_clk)
  begin
    if (rst || !switching)
      pulseSkip <= 1'b0;
    else if (cycleStart)
      pulseSkip <= sLight; // RL3
  end

  // valley limit sampled at each cycle boundary; counts overload run
  always_ff @(posedge core_clk)
  begin
    if (rst || !switching)
    begin
      valleyLimit <= 1'b0;
      overloadCount <= '0;
    end
    else if (cycleStart)
    begin
      valleyLimit <= sValley; // RL11 RL12
      if (sValley && overloadCount != 16'hFFFF)
        overloadCount <= overloadCount + CW'(1); // RL13
      else if (!sValley)
        overloadCount <= '0;
    end
  end

  // drive request for the current cycle
  logic wantHigh; // high-side should be on
  logic onPhase; // high-side on phase of this cycle, until peak trip
  logic highBlock;
  assign highBlock = sBootLow || overvoltageMask || !preBiasOk
    || !switching; // RL6 RL8 RL9

  always_ff @(posedge core_clk)
  begin
    if (rst || !switching)
      onPhase <= 1'b0;
    else if (cycleStart)
      // no pulse while skipping or over valley limit
      onPhase <= !sLight && !sValley; // RL2 RL3 RL11 RL12
    else if (sPeak)
      onPhase <= 1'b0; // RL2
  end
  // with no peak trip the on phase carries through; high-side still turns off at each cycle start
  assign wantHigh = onPhase && !highBlock && !cycleStart; // RL7

  logic wantLow;
  assign wantLow = preBiasOk && switching && !wantHigh; // RL9 RL11

  // break before make: a drive turns on only after the other is off
  logic [1:0] deadCnt;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      highDrive <= 1'b0;
      lowDrive <= 1'b0;
      deadCnt <= '0;
    end
    else if ((highDrive && !wantHigh) || (lowDrive && !wantLow))
    begin
      highDrive <= highDrive && wantHigh; // RL16
      lowDrive <= lowDrive && wantLow;
      deadCnt <= 2'(bsp_pkg::DEAD_CLKS);
    end
    else if (deadCnt != 2'h0)
      deadCnt <= deadCnt - 2'h1;
    else
    begin
      highDrive <= wantHigh && !lowDrive; // RL16
      lowDrive <= wantLow && !highDrive && !wantHigh;
    end
  end

  assign hiccupActive = (state == bsp_pkg::BSP_HICCUP);
  assign thermalActive = (state == bsp_pkg::BSP_THERMAL);
endmodule

// ==== rtl/bsp_pkg.sv ====
// constants and types shared by the buck switching protection sequencer
// Notes on behaviour
// RL1: fixed switching cycle rate, not user adjustable
// RL2: cycle start turns high-side on; peak trip swaps
// RL3: light peak current skips pulses until exceeded again
// RL4: enable high runs, low stops and idles
// RL5: supply lockout disables all switching
// RL6: boot undervoltage forces high-side off
// RL7: healthy boot supply allows full duty cycles (high-side still turns off at each cycle start)
// RL8: overvoltage masks high-side until lower threshold
// RL9: pre-bias: both off until soft-start passes feedback
// RL10: soft-start ramps over fixed duration each start
// RL11: valley limit at cycle end keeps low-side on
// RL12: high-side resumes only when valley under limit
// RL13: overload beyond wait count shuts down, restarts later
// RL14: overtemperature stops; count interval after clear, restart
// RL15: hiccup counters use oscillator; restarts redo soft-start
// RL16: never drive both switches; break before make
package bsp_pkg;
  // core clock rate in Hz and switching rate in Hz
  localparam int unsigned CORE_HZ = 10000000;
  localparam int unsigned SWITCH_HZ = 500000;
  // core cycles per switching cycle
  localparam int unsigned CYCLE_CLKS = CORE_HZ / SWITCH_HZ;
  // soft-start time in microseconds and its length in switching cycles
  localparam int unsigned SOFTSTART_US = 5000;
  localparam int unsigned SOFTSTART_CYC = SOFTSTART_US * (SWITCH_HZ / 1000)
    / 1000;
  // hiccup counts in switching cycles
  localparam int unsigned HIC_WAIT_CYC = 512;
  localparam int unsigned HIC_RESTART_CYC = 16384;
  localparam int unsigned THERM_HIC_CYC = 32768;
  // dead time between drives, in core cycles
  localparam int unsigned DEAD_CLKS = 1;
  // sequencer states
  typedef enum logic [2:0] {
    BSP_IDLE = 3'b000,
    BSP_SOFT = 3'b001,
    BSP_RUN = 3'b010,
    BSP_HICCUP = 3'b011,
    BSP_THERMAL = 3'b100
  } bsp_state_e;
endpackage

// ==== rtl/bsp_oscillator.sv ====
// switching oscillator: divides core clock to a cycle-start pulse
`timescale 1ns/1ps
module bsp_oscillator #(
  parameter int unsigned DIVIDE = bsp_pkg::CYCLE_CLKS
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic cycleStart
);
  localparam int unsigned W = $clog2(DIVIDE);
  // count of core cycles within one switching cycle
  logic [W-1:0] phase;

  // refuse a divide too short for the break-before-make sequence
  if (DIVIDE < 4)
  begin
    $error("oscillator divide too small");
  end

  // free-running divider; the rate is fixed by the parameter only
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase <= '0;
      cycleStart <= 1'b0;
    end
    else if (phase == W'(DIVIDE - 1))
    begin
      phase <= '0;
      cycleStart <= 1'b1; // RL1
    end
    else
    begin
      phase <= phase + W'(1);
      cycleStart <= 1'b0;
    end
  end
endmodule

// ==== bench/bsp_sequencer_assertions.sv ====
// concurrent checks on the sequencer drive and state outputs
`timescale 1ns/1ps
module bsp_sequencer_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enableAbove,
  input wire logic supplyLockout,
  input wire logic bootLow,
  input wire logic highDrive,
  input wire logic lowDrive,
  input wire logic [15:0] softLevel,
  input wire logic softDone,
  input wire logic pulseSkip,
  input wire logic overvoltageMask,
  input wire logic valleyLimit,
  input wire logic hiccupActive,
  input wire logic thermalActive
);
  // one clock domain, so clocking and disable are shared
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // overlap would short the input supply to ground
  no_overlap_a: assert property (!(highDrive && lowDrive))
    else $error("both drives on");
  dead_time_a: assert property (highDrive |=> !lowDrive)
    else $error("no dead time after high drive");
  // five edges cover the two sync flops plus state and drive regs
  lockout_off_a: assert property (supplyLockout [*5] |->
    !highDrive && !lowDrive) else $error("switching in lockout");
  enable_off_a: assert property (!enableAbove [*5] |->
    !highDrive && !lowDrive) else $error("switching while disabled");
  boot_off_a: assert property (bootLow [*5] |-> !highDrive)
    else $error("high drive with boot low");
  ov_mask_a: assert property (overvoltageMask [*2] |-> !highDrive)
    else $error("high drive while masked");
  skip_off_a: assert property (pulseSkip [*2] |-> !highDrive)
    else $error("high drive in pulse skip");
  valley_off_a: assert property (valleyLimit [*2] |-> !highDrive)
    else $error("high drive in valley limit");
  fault_off_a: assert property (
    (hiccupActive || thermalActive) [*2] |-> !highDrive && !lowDrive)
    else $error("switching in fault");
  soft_full_a: assert property (softDone |-> softLevel == 16'hFFFF)
    else $error("ramp not full in run");
endmodule
bind bsp_sequencer bsp_sequencer_assertions chk_u (.core_clk, .rst,
  .enableAbove, .supplyLockout, .bootLow, .highDrive, .lowDrive,
  .softLevel, .softDone, .pulseSkip, .overvoltageMask, .valleyLimit,
  .hiccupActive, .thermalActive);

// ==== bench/bsp_power_stage.sv ====
// power switch and peak current comparator model
`timescale 1ns/1ps
module bsp_power_stage (
  input wire logic core_clk,
  input wire logic highDrive,
  input wire logic slow, // heavy duty: current never reaches the peak
  output logic peakTrip
);
  int onCnt = 0; // clocks the high side has been on
  // trip five clocks into the on-time; current falls once switch opens
  always_ff @(posedge core_clk)
  begin
    onCnt <= highDrive ? onCnt + 1 : 0;
    peakTrip <= highDrive && !slow && onCnt >= 5;
  end
endmodule

// ==== bench/bsp_sequencer_tb.sv ====
// self-checking bench for the protection sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      errorCnt++; \
      $display("ERROR %s exp %0h got %0h", n, e, g); \
    end \
  end
module bsp_sequencer_tb;
  logic core_clk = 0, rst = 1, enableAbove = 0, supplyLockout = 1;
  logic bootLow = 0, lightLoad = 0, valleyOver = 0, overTemp = 0;
  logic overvoltageHigh = 0, overvoltageLow = 1, softAboveFb = 0;
  logic slow = 0, peakTrip, highDrive, lowDrive, softDone, pulseSkip;
  logic overvoltageMask, valleyLimit, hiccupActive, thermalActive;
  logic [15:0] softLevel;
  int errorCnt = 0, checked = 0;
  logic [7:0] hi, lo, rs; // duty tallies, four-state so unknowns show
  logic prev;
  // small counts keep each hiccup to a few hundred clocks
  bsp_sequencer #(.HIC_WAIT(4), .HIC_RESTART(8), .THERM_HIC(8),
    .SOFT_CYC(4), .CYCLE_DIV(20)) dut_u (.core_clk, .rst, .enableAbove,
    .supplyLockout, .bootLow, .peakTrip, .lightLoad, .valleyOver,
    .overvoltageHigh, .overvoltageLow, .overTemp, .softAboveFb,
    .highDrive, .lowDrive, .softLevel, .softDone, .pulseSkip,
    .overvoltageMask, .valleyLimit, .hiccupActive, .thermalActive);
  bsp_power_stage pwr_u (.core_clk, .highDrive, .slow, .peakTrip);
  initial forever #50 core_clk = ~core_clk;
  task go(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // tally drive clocks and high-side turn-ons over two cycles
  task duty();
    hi = 0;
    lo = 0;
    rs = 0;
    prev = highDrive;
    repeat (40)
    begin
      @(posedge core_clk);
      hi += highDrive;
      lo += lowDrive;
      rs += highDrive && !prev;
      prev = highDrive;
    end
  endtask
  task startUp();
    enableAbove <= 1;
    supplyLockout <= 0;
    go(50);
    `CHK("ramp busy", 1'b0, softDone)
    `CHK("ramp rising", 1'b1, softLevel > 0 && softLevel < 16'hFFFF)
    duty();
    `CHK("prebias off", 0, hi + lo)
    softAboveFb <= 1;
    go(30);
    `CHK("ramp done", 1'b1, softDone)
    `CHK("ramp full", 16'hFFFF, softLevel)
    duty();
    `CHK("turn ons", 2, rs)
    `CHK("peak cut", 1'b1, hi > 0 && hi < 30)
    `CHK("low after trip", 1'b1, lo > 0)
    slow <= 1;
    duty();
    `CHK("full duty", 1'b1, hi >= 30)
    slow <= 0;
  endtask
  task overVolt();
    overvoltageHigh <= 1;
    overvoltageLow <= 0;
    go(30);
    duty();
    `CHK("ov mask", 1'b1, overvoltageMask)
    `CHK("ov high", 0, hi)
    overvoltageHigh <= 0;
    go(30);
    `CHK("ov hold", 1'b1, overvoltageMask)
    overvoltageLow <= 1;
    go(30);
    `CHK("ov clear", 1'b0, overvoltageMask)
  endtask
  task skip();
    lightLoad <= 1;
    go(30);
    duty();
    `CHK("skip on", 1'b1, pulseSkip)
    `CHK("skip high", 0, hi)
    lightLoad <= 0;
    go(30);
    duty();
    `CHK("skip off", 1'b1, hi > 0 && !pulseSkip)
  endtask
  // entry comes at the fifth overloaded cycle start; restart 8 cycles later
  task overload();
    valleyOver <= 1;
    go(30);
    `CHK("valley", 1'b1, valleyLimit && lowDrive)
    go(70);
    `CHK("hiccup on", 1'b1, hiccupActive)
    valleyOver <= 0;
    go(80);
    `CHK("hiccup hold", 1'b1, hiccupActive)
    go(90);
    `CHK("hiccup end", 1'b0, hiccupActive)
    `CHK("hiccup soft", 1'b0, softDone)
    go(120);
    duty();
    `CHK("resumed", 1'b1, hi > 0)
  endtask
  task thermal();
    overTemp <= 1;
    go(10);
    `CHK("therm on", 1'b1, thermalActive)
    duty();
    `CHK("therm stop", 0, hi + lo)
    overTemp <= 0;
    go(120);
    `CHK("therm count", 1'b1, thermalActive)
    go(80);
    `CHK("therm end", 1'b0, thermalActive)
    `CHK("therm soft", 1'b0, softDone)
    go(150);
    `CHK("therm back", 1'b1, softDone)
  endtask
  task shutOff();
    enableAbove <= 0;
    go(10);
    duty();
    `CHK("disabled", 0, hi + lo + softDone)
    enableAbove <= 1;
    go(150);
    `CHK("reenabled", 1'b1, softDone)
    supplyLockout <= 1;
    go(10);
    duty();
    `CHK("lockout", 0, hi + lo)
    supplyLockout <= 0;
    bootLow <= 1;
    go(150);
    duty();
    `CHK("boot low", 1'b1, hi == 0 && lo > 0)
    bootLow <= 0;
  endtask
  task endSim();
    if (errorCnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // whole sequence needs about 1800 clocks
  initial
  begin
    go(20000);
    errorCnt++;
    endSim();
  end
  initial
  begin
    go(20);
    rst <= 0;
    startUp();
    overVolt();
    skip();
    overload();
    thermal();
    shutOff();
    endSim();
  end
endmodule
